/* File: pkg/cgr_consts.vh */
`ifndef CGR_CONSTS_VH
`define CGR_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (command byte bits 6:0)
// ----------------------------------------------------------------------
`define CGR_OFS_FREQ         7'h00
`define CGR_OFS_CPU          7'h01
`define CGR_OFS_BUS          7'h02
`define CGR_OFS_GFX          7'h03
`define CGR_OFS_PERIPH       7'h04

// ----------------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------------
`define CGR_CMD_BYTE_OP_BIT  7

// ----------------------------------------------------------------------
// Frequency select register fields
// ----------------------------------------------------------------------
`define CGR_FREQ_SWEN_BIT    3
`define CGR_FREQ_B3_BIT      1
`define CGR_FREQ_MODE_BIT    0
`define CGR_FREQ_RSVD2_BIT   2

// ----------------------------------------------------------------------
// CPU clocks register fields
// ----------------------------------------------------------------------
`define CGR_CPU_TYPE_BIT     7
`define CGR_CPU_SPREN_BIT    6
`define CGR_CPU_BW_HI        5
`define CGR_CPU_BW_LO        4
`define CGR_CPU_PAIRA_BIT    3
`define CGR_CPU_PAIRB_BIT    2
`define CGR_CPU_PDCTL_BIT    1
`define CGR_CPU_MULT_BIT     0

// ----------------------------------------------------------------------
// Reset values and writable masks of the plain storage bytes
// ----------------------------------------------------------------------
`define CGR_CPU_RST          8'h7C
`define CGR_CPU_WMASK        8'hFE
`define CGR_BUS_RST          8'h7F
`define CGR_BUS_WMASK        8'hDF
`define CGR_BUS_RMASK1       8'h20
`define CGR_GFX_RST          8'h67
`define CGR_GFX_WMASK        8'hFB
`define CGR_GFX_RMASK1       8'h04
`define CGR_PER_RST          8'hCF
`define CGR_PER_WMASK        8'hFF

// ----------------------------------------------------------------------
// Spread depth in hundredths of a percent
// ----------------------------------------------------------------------
`define CGR_DOWN_BW0         8'h96
`define CGR_DOWN_BW1         8'h64
`define CGR_DOWN_BW2         8'h46
`define CGR_DOWN_BW3         8'h32
`define CGR_CTR_BW0          8'h4B
`define CGR_CTR_BW1          8'h32
`define CGR_CTR_BW2          8'h23
`define CGR_CTR_BW3          8'h19

// ----------------------------------------------------------------------
// Skew shift in ps (two's complement) and ratio times two
// ----------------------------------------------------------------------
`define CGR_SKEW_0           10'h000
`define CGR_SKEW_1           10'h2E8
`define CGR_SKEW_2           10'h118
`define CGR_SKEW_3           10'h1E0
`define CGR_RATIO_0          3'h0
`define CGR_RATIO_1          3'h4
`define CGR_RATIO_2          3'h5
`define CGR_RATIO_3          3'h6

`endif

/* File: rtl/cgr_config_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "cgr_consts.vh"

module cgr_config_regs (
  input  wire       core_clk,
  input  wire       resetn,
  input  wire       hostWrEn,
  input  wire       hostRdEn,
  input  wire [7:0] hostCmd,
  input  wire [7:0] hostWrData,
  output reg  [7:0] hostRdData,
  output reg        hostRdValid,
  input  wire       freq_sel_b0,
  input  wire       freq_sel_b1,
  input  wire       freq_sel_b2,
  input  wire       freq_sel_b3,
  input  wire       cpu_iface_mode_strap,
  input  wire       multiplier_strap,
  input  wire       power_down_n,
  output reg  [3:0] freqSelect,
  output reg        cpuIfaceMode,
  output reg        spread_type_sel,
  output reg        spread_enable,
  output reg  [1:0] spreadBw,
  output reg  [7:0] spreadDepth,
  output reg        cpu_pair_a_enable,
  output reg        cpu_pair_b_enable,
  output reg        cpuPairDriveTrue,
  output reg        cpuPairTristate,
  output reg        busDriveBoost,
  output reg        busFreeClkEnable,
  output reg  [4:0] busClkEnable,
  output reg        selPeriph48,
  output reg        fixed_periph_clk_enable,
  output reg        selPeriphEnable,
  output reg  [1:0] gfxSkew,
  output reg  [9:0] gfxSkewPs,
  output reg  [1:0] gfxClkEnable,
  output reg        fixedPeriphSingle,
  output reg        selPeriphSingle,
  output reg  [1:0] gfxRatio,
  output reg  [2:0] gfxRatioX2,
  output reg        ref0Enable,
  output reg        ref1Enable,
  output reg        ref0Single,
  output reg        ref1Single
);

  // ----------------------------------------------------------------------
  // Strap and pin synchronisers
  // ----------------------------------------------------------------------
  // Order: power_down_n, multiplier, mode, freq b3..b0
  localparam NPIN = 7;

  // Straps may move at any time relative to core_clk, so each one is
  // filtered before it can reach a register read or a decoded output
  wire [NPIN-1:0] pinRaw;
  wire [NPIN-1:0] pinStable;

  assign pinRaw = {power_down_n, multiplier_strap, cpu_iface_mode_strap,
                   freq_sel_b3, freq_sel_b2, freq_sel_b1, freq_sel_b0};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : gPinSync
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg stab_r;
      // Each bit owns its filtered flop so the vector has one driver per bit
      assign pinStable[gi] = stab_r;
      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          s1_r   <= 1'b0;
          s2_r   <= 1'b0;
          s3_r   <= 1'b0;
          stab_r <= 1'b0;
        end else begin
          s1_r <= pinRaw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // A change counts only once two later stages agree
          if (s2_r == s3_r) begin
            stab_r <= s3_r;
          end
        end
      end
    end
  endgenerate

  wire [3:0] strapFreq;
  wire       strapMode;
  wire       strapMult;
  wire       pdLevelN;

  assign strapFreq = pinStable[3:0];
  assign strapMode = pinStable[4];
  assign strapMult = pinStable[5];
  assign pdLevelN  = pinStable[6];

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  reg       swSelEn_r;
  reg [3:0] swFreq_r;
  reg [7:0] cpuCtl_r;
  reg [7:0] busCtl_r;
  reg [7:0] gfxCtl_r;
  reg [7:0] perCtl_r;

  // ----------------------------------------------------------------------
  // Host command decode
  // ----------------------------------------------------------------------
  wire       byteOp;
  wire [6:0] ofs;
  wire       wrOk;

  // Only single-byte commands are served; block commands are dropped
  assign byteOp = hostCmd[`CGR_CMD_BYTE_OP_BIT];
  assign ofs    = hostCmd[6:0];
  assign wrOk   = hostWrEn & byteOp;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      swSelEn_r <= 1'b0;
      swFreq_r  <= 4'h0;
      cpuCtl_r  <= `CGR_CPU_RST;
      busCtl_r  <= `CGR_BUS_RST;
      gfxCtl_r  <= `CGR_GFX_RST;
      perCtl_r  <= `CGR_PER_RST;
    end else begin
      // While software select is off, the held value follows the straps,
      // so turning it on starts from the strapped frequency
      if (!swSelEn_r) begin
        swFreq_r <= strapFreq;
      end
      if (wrOk) begin
        if (ofs == `CGR_OFS_FREQ) begin
          swSelEn_r <= hostWrData[`CGR_FREQ_SWEN_BIT];
          // Frequency bits only take writes while the enable is already set
          if (swSelEn_r) begin
            swFreq_r <= {hostWrData[`CGR_FREQ_B3_BIT], hostWrData[6:4]};
          end
        end else if (ofs == `CGR_OFS_CPU) begin
          cpuCtl_r <= hostWrData & `CGR_CPU_WMASK;
        end else if (ofs == `CGR_OFS_BUS) begin
          // Reserved bits of the bus and graphics bytes always hold one
          busCtl_r <= (hostWrData & `CGR_BUS_WMASK) | `CGR_BUS_RMASK1;
        end else if (ofs == `CGR_OFS_GFX) begin
          gfxCtl_r <= (hostWrData & `CGR_GFX_WMASK) | `CGR_GFX_RMASK1;
        end else if (ofs == `CGR_OFS_PERIPH) begin
          perCtl_r <= hostWrData & `CGR_PER_WMASK;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire [3:0] freqEff;
  reg  [7:0] rdMux;

  assign freqEff = swSelEn_r ? swFreq_r : strapFreq;

  // Undecoded offsets and block commands read back as zero; a write in the
  // same cycle is not yet visible, so the host sees the old byte
  always @* begin
    rdMux = 8'h00;
    if (!byteOp) begin
      rdMux = 8'h00;
    end else if (ofs == `CGR_OFS_FREQ) begin
      rdMux = {1'b0, freqEff[2:0], swSelEn_r, strapMult, freqEff[3], strapMode};
    end else if (ofs == `CGR_OFS_CPU) begin
      rdMux = {cpuCtl_r[7:1], strapMult};
    end else if (ofs == `CGR_OFS_BUS) begin
      rdMux = busCtl_r;
    end else if (ofs == `CGR_OFS_GFX) begin
      rdMux = gfxCtl_r;
    end else if (ofs == `CGR_OFS_PERIPH) begin
      rdMux = perCtl_r;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hostRdData  <= 8'h00;
      hostRdValid <= 1'b0;
    end else begin
      hostRdValid <= hostRdEn;
      if (hostRdEn) begin
        hostRdData <= rdMux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Spread, skew and ratio lookup
  // ----------------------------------------------------------------------
  reg [7:0] depthNxt;
  reg [9:0] skewNxt;
  reg [2:0] ratioNxt;
  wire      firstMode;
  wire      pdCtl;

  // Mode strap low selects the first CPU interface mode
  assign firstMode = ~strapMode;
  assign pdCtl     = cpuCtl_r[`CGR_CPU_PDCTL_BIT];

  always @* begin
    // Depth in hundredths of a percent, down or centre by the type bit
    depthNxt = `CGR_DOWN_BW0;
    case ({cpuCtl_r[`CGR_CPU_TYPE_BIT], cpuCtl_r[`CGR_CPU_BW_HI:`CGR_CPU_BW_LO]})
      3'b000:  depthNxt = `CGR_DOWN_BW0;
      3'b001:  depthNxt = `CGR_DOWN_BW1;
      3'b010:  depthNxt = `CGR_DOWN_BW2;
      3'b011:  depthNxt = `CGR_DOWN_BW3;
      3'b100:  depthNxt = `CGR_CTR_BW0;
      3'b101:  depthNxt = `CGR_CTR_BW1;
      3'b110:  depthNxt = `CGR_CTR_BW2;
      default: depthNxt = `CGR_CTR_BW3;
    endcase

    // Skew in picoseconds, two's complement so the negative step fits
    skewNxt = `CGR_SKEW_0;
    case (gfxCtl_r[4:3])
      2'b00:   skewNxt = `CGR_SKEW_0;
      2'b01:   skewNxt = `CGR_SKEW_1;
      2'b10:   skewNxt = `CGR_SKEW_2;
      default: skewNxt = `CGR_SKEW_3;
    endcase

    // Ratio held times two so the half step stays an integer
    ratioNxt = `CGR_RATIO_0;
    case (perCtl_r[5:4])
      2'b00:   ratioNxt = `CGR_RATIO_0;
      2'b01:   ratioNxt = `CGR_RATIO_1;
      2'b10:   ratioNxt = `CGR_RATIO_2;
      default: ratioNxt = `CGR_RATIO_3;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registered control outputs
  // ----------------------------------------------------------------------
  // Enables are registered once here; the analogue stages stop the clocks
  // on their own without waiting for a clock edge
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      freqSelect              <= 4'h0;
      cpuIfaceMode            <= 1'b0;
      spread_type_sel         <= 1'b0;
      spread_enable           <= 1'b1;
      spreadBw                <= 2'b11;
      spreadDepth             <= `CGR_DOWN_BW3;
      cpu_pair_a_enable       <= 1'b1;
      cpu_pair_b_enable       <= 1'b1;
      cpuPairDriveTrue        <= 1'b0;
      cpuPairTristate         <= 1'b0;
      busDriveBoost           <= 1'b0;
      busFreeClkEnable        <= 1'b1;
      busClkEnable            <= 5'h1F;
      selPeriph48             <= 1'b0;
      fixed_periph_clk_enable <= 1'b1;
      selPeriphEnable         <= 1'b1;
      gfxSkew                 <= 2'b00;
      gfxSkewPs               <= `CGR_SKEW_0;
      gfxClkEnable            <= 2'b11;
      fixedPeriphSingle       <= 1'b1;
      selPeriphSingle         <= 1'b1;
      gfxRatio                <= 2'b00;
      gfxRatioX2              <= `CGR_RATIO_0;
      ref0Enable              <= 1'b1;
      ref1Enable              <= 1'b1;
      ref0Single              <= 1'b1;
      ref1Single              <= 1'b1;
    end else begin
      // Frequency and CPU pair controls
      freqSelect              <= freqEff;
      cpuIfaceMode            <= strapMode;
      spread_type_sel         <= cpuCtl_r[`CGR_CPU_TYPE_BIT];
      spread_enable           <= cpuCtl_r[`CGR_CPU_SPREN_BIT];
      spreadBw                <= cpuCtl_r[`CGR_CPU_BW_HI:`CGR_CPU_BW_LO];
      spreadDepth             <= depthNxt;
      cpu_pair_a_enable       <= cpuCtl_r[`CGR_CPU_PAIRA_BIT];
      cpu_pair_b_enable       <= cpuCtl_r[`CGR_CPU_PAIRB_BIT];
      cpuPairDriveTrue        <= ~firstMode & ~pdLevelN & ~pdCtl;
      cpuPairTristate         <= ~firstMode & ~pdLevelN & pdCtl;
      // Bus clock controls
      busDriveBoost           <= busCtl_r[7];
      busFreeClkEnable        <= busCtl_r[6];
      busClkEnable            <= busCtl_r[4:0];
      // Graphics and peripheral clock controls
      selPeriph48             <= gfxCtl_r[7];
      fixed_periph_clk_enable <= gfxCtl_r[6];
      selPeriphEnable         <= gfxCtl_r[5];
      gfxSkew                 <= gfxCtl_r[4:3];
      gfxSkewPs               <= skewNxt;
      gfxClkEnable            <= gfxCtl_r[1:0];
      // Strength, ratio and reference controls
      fixedPeriphSingle       <= perCtl_r[7];
      selPeriphSingle         <= perCtl_r[6];
      gfxRatio                <= perCtl_r[5:4];
      gfxRatioX2              <= ratioNxt;
      ref0Enable              <= perCtl_r[3];
      ref0Single              <= perCtl_r[1];
      // Second reference pin is unused outside the first mode: enable held low, single held high
      ref1Enable              <= firstMode & perCtl_r[2];
      ref1Single              <= ~firstMode | perCtl_r[0];
    end
  end

endmodule
`default_nettype wire

/* File: testbench/cgr_config_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cgr_config_regs_checker (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       hostWrEn,
  input wire logic       hostRdEn,
  input wire logic [7:0] hostCmd,
  input wire logic [7:0] hostWrData,
  input wire logic [7:0] hostRdData,
  input wire logic       hostRdValid,
  input wire logic       cpuIfaceMode,
  input wire logic       spread_enable,
  input wire logic       spread_type_sel,
  input wire logic [1:0] spreadBw,
  input wire logic [7:0] spreadDepth,
  input wire logic       cpuPairDriveTrue,
  input wire logic       cpuPairTristate,
  input wire logic [4:0] busClkEnable,
  input wire logic [1:0] gfxSkew,
  input wire logic [9:0] gfxSkewPs,
  input wire logic [1:0] gfxRatio,
  input wire logic [2:0] gfxRatioX2,
  input wire logic       ref1Enable,
  input wire logic       ref1Single
);
  logic [7:0] dTab [8] = '{8'h96, 8'h64, 8'h46, 8'h32, 8'h4B, 8'h32, 8'h23, 8'h19};
  logic [9:0] sTab [4] = '{10'h000, 10'h2E8, 10'h118, 10'h1E0};
  logic [2:0] rTab [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  read_valid_pulse_a: assert property (hostRdValid == $past(hostRdEn))
    else $error("read valid does not follow read strobe");
  refused_read_zero_a: assert property (hostRdEn && !hostCmd[7] |=> hostRdData == 8'h00)
    else $error("block read returned data");
  reserved_bit_one_a: assert property (hostRdEn && hostCmd == 8'h82 |=> hostRdData[5])
    else $error("reserved bus bit read as zero");
  spread_write_a: assert property (hostWrEn && hostCmd == 8'h81 |-> ##2
    spread_enable == $past(hostWrData[6], 2) && spreadBw == $past(hostWrData[5:4], 2))
    else $error("spread fields not taken from write");
  depth_table_a: assert property (spreadDepth == dTab[{spread_type_sel, spreadBw}])
    else $error("spread depth mismatch");
  skew_table_a: assert property (gfxSkewPs == sTab[gfxSkew])
    else $error("skew shift mismatch");
  ratio_table_a: assert property (gfxRatioX2 == rTab[gfxRatio])
    else $error("ratio mismatch");
  second_mode_ref_a: assert property (cpuIfaceMode [*2] |-> !ref1Enable && ref1Single)
    else $error("second reference active in second mode");
  pair_drive_excl_a: assert property (!(cpuPairDriveTrue && cpuPairTristate))
    else $error("pair both driven and tristated");
  bus_enable_write_a: assert property (hostWrEn && hostCmd == 8'h82 |-> ##2
    busClkEnable == $past(hostWrData[4:0], 2))
    else $error("bus enables not taken from write");
  cover property (hostWrEn && hostCmd == 8'h80 && hostWrData[3]);
  cover property (cpuPairTristate);
  cover property (hostRdEn && !hostCmd[7]);
endmodule
bind cgr_config_regs cgr_config_regs_checker chk_i (.*);
`default_nettype wire

/* File: testbench/cgr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cgr_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] hostRdData,
  input  wire logic       hostRdValid,
  output var  logic       hostWrEn,
  output var  logic       hostRdEn,
  output var  logic [7:0] hostCmd,
  output var  logic [7:0] hostWrData
);
  initial begin
    hostWrEn = 1'b0;
    hostRdEn = 1'b0;
    hostCmd = 8'h00;
    hostWrData = 8'h00;
  end
  // Released lines flip so a stale value is never mistaken for a live one
  task automatic wr(input logic op, input logic [6:0] ofs, input logic [7:0] d);
    @(negedge core_clk);
    hostWrEn <= 1'b1;
    hostCmd <= {op, ofs};
    hostWrData <= d;
    @(negedge core_clk);
    hostWrEn <= 1'b0;
    hostCmd <= ~hostCmd;
    hostWrData <= ~hostWrData;
  endtask
  task automatic rd(input logic op, input logic [6:0] ofs, output logic [7:0] d,
                    output logic v);
    @(negedge core_clk);
    hostRdEn <= 1'b1;
    hostCmd <= {op, ofs};
    @(negedge core_clk);
    d = hostRdData;
    v = hostRdValid;
    hostRdEn <= 1'b0;
    hostCmd <= ~hostCmd;
  endtask
endmodule
`default_nettype wire

/* File: testbench/cgr_config_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cgr_config_regs_bench;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [3:0] fs = 4'h0;
  logic       mode = 1'b0;
  logic       mult = 1'b0;
  logic       pdN = 1'b1;
  logic [31:0] seed;
  int         n_errors = 0;
  int         n_tests = 0;
  wire        hostWrEn, hostRdEn, hostRdValid, spread_type_sel, ref1Enable, ref1Single;
  wire        cpuPairDriveTrue, cpuPairTristate;
  wire [7:0]  hostCmd, hostWrData, hostRdData, spreadDepth;
  wire [3:0]  freqSelect;
  wire [4:0]  busClkEnable;
  wire [9:0]  gfxSkewPs;
  wire [2:0]  gfxRatioX2;
  logic [7:0] dTab [8] = '{8'h96, 8'h64, 8'h46, 8'h32, 8'h4B, 8'h32, 8'h23, 8'h19};
  logic [9:0] sTab [4] = '{10'h000, 10'h2E8, 10'h118, 10'h1E0};
  logic [2:0] rTab [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
  always #2.5 core_clk = ~core_clk;
  cgr_host_model host (.core_clk(core_clk), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
    .hostCmd(hostCmd), .hostWrData(hostWrData));
  cgr_config_regs uut (.core_clk(core_clk), .resetn(resetn), .hostWrEn(hostWrEn),
    .hostRdEn(hostRdEn), .hostCmd(hostCmd), .hostWrData(hostWrData),
    .hostRdData(hostRdData), .hostRdValid(hostRdValid), .freq_sel_b0(fs[0]),
    .freq_sel_b1(fs[1]), .freq_sel_b2(fs[2]), .freq_sel_b3(fs[3]),
    .cpu_iface_mode_strap(mode), .multiplier_strap(mult), .power_down_n(pdN),
    .freqSelect(freqSelect), .cpuIfaceMode(), .spread_type_sel(spread_type_sel),
    .spread_enable(), .spreadBw(), .spreadDepth(spreadDepth), .cpu_pair_a_enable(),
    .cpu_pair_b_enable(), .cpuPairDriveTrue(cpuPairDriveTrue),
    .cpuPairTristate(cpuPairTristate), .busDriveBoost(), .busFreeClkEnable(),
    .busClkEnable(busClkEnable), .selPeriph48(), .fixed_periph_clk_enable(),
    .selPeriphEnable(), .gfxSkew(), .gfxSkewPs(gfxSkewPs), .gfxClkEnable(),
    .fixedPeriphSingle(), .selPeriphSingle(), .gfxRatio(), .gfxRatioX2(gfxRatioX2),
    .ref0Enable(), .ref1Enable(ref1Enable), .ref0Single(), .ref1Single(ref1Single));
  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic op, input logic [6:0] o, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(op, o, d, v);
    chk("hostRdValid", {9'h000, v}, 10'h001);
    chk("hostRdData", {2'b00, d}, {2'b00, exp});
  endtask
  // Stored bytes as read back; strap and reserved bits are not writable
  function automatic logic [7:0] expRd(input logic [6:0] o, input logic [7:0] d);
    case (o)
      7'h01: return {d[7:1], mult};
      7'h02: return d | 8'h20;
      7'h03: return d | 8'h04;
      default: return d;
    endcase
  endfunction
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    close_out();
  end
  initial begin
    logic [7:0] fx, d;
    logic [6:0] o;
    seed = 32'h511f;
    fs = 4'($random(seed));
    mult = 1'($random(seed));
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    repeat (8) @(negedge core_clk);
    fx = {1'b0, fs[2:0], 1'b0, mult, fs[3], mode};
    rchk(1'b1, 7'h00, fx);
    chk("freqSelect", freqSelect, fs);
    rchk(1'b1, 7'h01, {7'h3E, mult});
    rchk(1'b1, 7'h02, 8'h7F);
    rchk(1'b1, 7'h03, 8'h67);
    rchk(1'b1, 7'h04, 8'hCF);
    $display("reset values done");
    host.wr(1'b1, 7'h00, 8'h77);
    rchk(1'b1, 7'h00, fx);
    host.wr(1'b1, 7'h00, 8'h08);
    rchk(1'b1, 7'h00, fx | 8'h08);
    host.wr(1'b1, 7'h00, 8'h5A);
    rchk(1'b1, 7'h00, {5'b0101_1, mult, 1'b1, mode});
    chk("freqSelect", freqSelect, 4'hD);
    $display("frequency select done");
    for (int i = 0; i < 24; i++) begin
      o = 7'h01 + 7'($random(seed) & 3);
      d = 8'($random(seed));
      host.wr(1'b1, o, d);
      rchk(1'b1, o, expRd(o, d));
    end
    $display("random writes done");
    for (int c = 0; c < 8; c++) begin
      host.wr(1'b1, 7'h01, {c[2], 1'b1, c[1:0], 4'hC});
      @(negedge core_clk);
      chk("spreadDepth", spreadDepth, dTab[c]);
      chk("spread_type_sel", spread_type_sel, c[2]);
    end
    for (int c = 0; c < 4; c++) begin
      host.wr(1'b1, 7'h03, {3'b011, c[1:0], 3'b111});
      host.wr(1'b1, 7'h04, {2'b11, c[1:0], 4'hF});
      @(negedge core_clk);
      chk("gfxSkewPs", gfxSkewPs, sTab[c]);
      chk("gfxRatioX2", gfxRatioX2, rTab[c]);
    end
    $display("tables done");
    host.wr(1'b0, 7'h04, 8'h00);
    host.wr(1'b1, 7'h05, 8'h00);
    rchk(1'b1, 7'h04, 8'hFF);
    rchk(1'b0, 7'h01, 8'h00);
    rchk(1'b1, 7'h05, 8'h00);
    host.wr(1'b1, 7'h02, 8'h00);
    @(negedge core_clk);
    chk("busClkEnable", busClkEnable, 5'h00);
    chk("ref1Enable", ref1Enable, 1'b1);
    $display("refusals done");
    mode = 1'b1;
    pdN = 1'b0;
    host.wr(1'b1, 7'h01, 8'h7E);
    repeat (8) @(negedge core_clk);
    chk("cpuPairTristate", cpuPairTristate, 1'b1);
    chk("ref1Enable", ref1Enable, 1'b0);
    host.wr(1'b1, 7'h01, 8'h7C);
    @(negedge core_clk);
    chk("cpuPairDriveTrue", cpuPairDriveTrue, 1'b1);
    $display("second mode done");
    close_out();
  end
endmodule
`default_nettype wire
